// file: rtl/hpd_pkg.sv
/*
  Shared constants for the host port block: register offsets, field
  positions, reset values and the handshake state encoding.
  Assumes a 32-bit Avalon-MM slave port with byte addressing.
*/
package hpd_pkg;
  // Bus widths
  localparam int HPD_AW = 8;
  localparam int HPD_DW = 32;

  // Register byte offsets
  localparam logic [7:0] HPD_OFF_CTRL = 8'h00;
  localparam logic [7:0] HPD_OFF_EVENT = 8'h04;
  localparam logic [7:0] HPD_OFF_HOSTACC = 8'h08;
  localparam logic [7:0] HPD_OFF_DMACMD = 8'h0c;
  localparam logic [7:0] HPD_OFF_DMALEN = 8'h10;
  localparam logic [7:0] HPD_OFF_FEATURE = 8'h14;
  localparam logic [7:0] HPD_OFF_STATUS = 8'h18;
  localparam logic [7:0] HPD_OFF_COUNT = 8'h1c;

  // Control register fields
  localparam int HPD_CTRL_NIEN = 0;
  localparam int HPD_CTRL_BSY = 1;
  localparam int HPD_CTRL_DRQ = 2;
  localparam int HPD_CTRL_DEV = 3;
  localparam int HPD_CTRL_UNIT1 = 4;
  localparam int HPD_CTRL_PKT = 5;
  localparam int HPD_CTRL_OVL = 6;
  localparam int HPD_CTRL_RELIE = 7;
  localparam int HPD_CTRL_SVCIE = 8;
  localparam int HPD_CTRL_PID_LO = 9;
  localparam int HPD_CTRL_PIOIN = 11;
  localparam int HPD_CTRL_DMARDY = 12;
  localparam int HPD_CTRL_W = 13;
  localparam logic [12:0] HPD_CTRL_RST = 13'h0001;

  // Event register bits (write one to signal)
  localparam int HPD_EV_CMD_OK = 0;
  localparam int HPD_EV_CMD_ERR = 1;
  localparam int HPD_EV_PIN_BLK = 2;
  localparam int HPD_EV_POUT_BLK = 3;
  localparam int HPD_EV_PKT_RDY = 4;
  localparam int HPD_EV_PKT_DRQ = 5;
  localparam int HPD_EV_BUS_REL = 6;
  localparam int HPD_EV_BUS_CONT = 7;
  localparam int HPD_EV_SVC_RDY = 8;
  localparam int HPD_EV_DIAG = 9;
  localparam int HPD_EV_FIRST = 10;

  // Host access report bits
  localparam int HPD_HA_STAT_RD = 0;
  localparam int HPD_HA_CMD_WR = 1;
  localparam int HPD_HA_SRST = 2;

  // DMA command bits
  localparam int HPD_DC_START = 0;
  localparam int HPD_DC_ABORT = 1;

  // Feature codes and values
  localparam logic [7:0] HPD_SUB_XFER_MODE = 8'h03;
  localparam logic [7:0] HPD_MODE_RST = 8'h00;
  localparam logic [1:0] HPD_PID_INTR = 2'b01;

  // Synchroniser inputs: dmack, dior, diow, cs0, cs1 (all active low)
  localparam int HPD_SYNC_W = 5;
  localparam logic [4:0] HPD_SYNC_RST = 5'h1f;

  // Handshake states, Gray coded along idle-req-xfer-pause-finish
  typedef enum logic [2:0] {
    HPD_IDLE = 3'b000,
    HPD_REQ = 3'b001,
    HPD_XFER = 3'b011,
    HPD_PAUSE = 3'b010,
    HPD_FINISH = 3'b110
  } hpd_state_type;
endpackage

// file: rtl/hpd_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous levels; only the second stage
  is visible to the rest of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module hpd_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pin side
  input wire logic [WIDTH-1:0] pin_in,
  // Clock domain side
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r; // First stage, read only by second stage

  // Two stages, reset to the inactive pin level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: rtl/hpd_top.sv
/*
  Device-side host port: interrupt pending state and Multiword DMA
  request/acknowledge handshake, with an Avalon-MM register slave.
  Assumes firmware reports command events and host register accesses
  through registers, and that host pins are asynchronous to clock.
*/
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module hpd_top
  import hpd_pkg::*;
#(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [hpd_pkg::HPD_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [hpd_pkg::HPD_DW-1:0] avs_writedata,
  output logic [hpd_pkg::HPD_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Host pins, active low, asynchronous
  input wire logic dmack_n,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  // Device pins
  output logic dmarq_o,
  output logic dmarq_oe,
  output logic intrq
);
  import hpd_pkg::*;

  // Synchronised host pins
  logic [HPD_SYNC_W-1:0] pins_s;
  logic dmack_s; // Acknowledge asserted, synchronised
  logic strobe_s; // Either data strobe asserted while acknowledge is asserted
  logic strobe_d_r; // Previous strobe level
  logic word_done; // End of one strobe pulse

  // Register state
  logic [HPD_CTRL_W-1:0] ctrl_r;
  logic [LEN_W-1:0] len_r;
  logic [LEN_W-1:0] count_r;
  logic [7:0] mode_r;
  logic pend_r;
  logic done_r;
  logic err_r;
  logic burst_word_r; // A word moved since acknowledge rose
  hpd_state_type state_r;

  // Bus access decode
  logic acc_req;
  logic wr_acc;
  logic [HPD_DW-1:0] rd_mux;
  logic [10:0] ev;
  logic [2:0] ha;
  logic [1:0] dc;
  logic selected;
  logic set_pend;
  logic clr_pend;

  // Pin synchroniser
  hpd_sync #(
    .WIDTH(HPD_SYNC_W),
    .RST_VAL(HPD_SYNC_RST)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in({cs1_n, cs0_n, diow_n, dior_n, dmack_n}),
    .sync_out(pins_s)
  );

  // Decoded host levels; chip selects are not needed by the device here
  assign dmack_s = ~pins_s[0];
  assign strobe_s = dmack_s & (~pins_s[1] | ~pins_s[2]);
  assign word_done = strobe_d_r & ~strobe_s;

  // Strobe edge history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= strobe_s;
    end
  end

  // Accept a request in the cycle waitrequest is low
  assign acc_req = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_acc = acc_req & avs_write;

  // Write pulses for the strobe-only registers
  assign ev = (wr_acc && avs_address == HPD_OFF_EVENT) ? avs_writedata[10:0] : 11'h000;
  assign ha = (wr_acc && avs_address == HPD_OFF_HOSTACC) ? avs_writedata[2:0] : 3'h0;
  assign dc = (wr_acc && avs_address == HPD_OFF_DMACMD) ? avs_writedata[1:0] : 2'h0;

  // Waitrequest: high at rest, low for one cycle per request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data mux, unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      HPD_OFF_CTRL: begin
        rd_mux[HPD_CTRL_W-1:0] = ctrl_r;
      end
      HPD_OFF_DMALEN: begin
        rd_mux[LEN_W-1:0] = len_r;
      end
      HPD_OFF_STATUS: begin
        rd_mux[0] = pend_r;
        rd_mux[1] = intrq;
        rd_mux[4:2] = state_r;
        rd_mux[5] = done_r;
        rd_mux[6] = err_r;
        rd_mux[15:8] = mode_r;
      end
      HPD_OFF_COUNT: begin
        rd_mux[LEN_W-1:0] = count_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data captured as waitrequest falls, valid at the accept edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // Control register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= HPD_CTRL_RST;
    end else if (wr_acc && avs_address == HPD_OFF_CTRL) begin
      ctrl_r <= avs_writedata[HPD_CTRL_W-1:0];
    end
  end

  // Transfer length register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      len_r <= '0;
    end else if (wr_acc && avs_address == HPD_OFF_DMALEN) begin
      len_r <= avs_writedata[LEN_W-1:0];
    end
  end

  // Transfer mode, changed only by the set-transfer-mode subcommand
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_r <= HPD_MODE_RST;
    end else if (wr_acc && avs_address == HPD_OFF_FEATURE
                 && avs_writedata[7:0] == HPD_SUB_XFER_MODE) begin
      mode_r <= avs_writedata[15:8];
    end
  end

  // This device is the one the host addresses; the select bit alone
  // never touches the pending state
  assign selected = (ctrl_r[HPD_CTRL_DEV] == ctrl_r[HPD_CTRL_UNIT1]);

  // Qualified events that enter the pending state
  always_comb begin
    set_pend = 1'b0;
    if (ev[HPD_EV_CMD_OK] && !ctrl_r[HPD_CTRL_PIOIN]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_CMD_ERR]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_PIN_BLK]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_POUT_BLK] && !ev[HPD_EV_FIRST]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_PKT_RDY] && ctrl_r[HPD_CTRL_PKT]
        && ctrl_r[HPD_CTRL_PID_LO+1:HPD_CTRL_PID_LO] == HPD_PID_INTR) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_PKT_DRQ] && ctrl_r[HPD_CTRL_PKT]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_BUS_REL] && ctrl_r[HPD_CTRL_OVL] && ctrl_r[HPD_CTRL_RELIE]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_BUS_CONT] && ctrl_r[HPD_CTRL_OVL]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_SVC_RDY] && ctrl_r[HPD_CTRL_OVL] && ctrl_r[HPD_CTRL_SVCIE]) begin
      set_pend = 1'b1;
    end
    if (ev[HPD_EV_DIAG] && !ctrl_r[HPD_CTRL_UNIT1]) begin
      set_pend = 1'b1;
    end
  end

  // Host accesses that leave the pending state
  always_comb begin
    clr_pend = 1'b0;
    if (ha[HPD_HA_STAT_RD] && selected && !ctrl_r[HPD_CTRL_BSY]) begin
      clr_pend = 1'b1;
    end
    if (ha[HPD_HA_CMD_WR] && selected && !ctrl_r[HPD_CTRL_BSY]
        && !ctrl_r[HPD_CTRL_DRQ]) begin
      clr_pend = 1'b1;
    end
  end

  // Pending state: soft reset wins, then a new event beats a clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
    end else if (ha[HPD_HA_SRST]) begin
      pend_r <= 1'b0;
    end else if (set_pend) begin
      pend_r <= 1'b1;
    end else if (clr_pend) begin
      pend_r <= 1'b0;
    end
  end

  // Interrupt pin follows pending while interrupts are enabled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      intrq <= 1'b0;
    end else begin
      intrq <= pend_r & ~ctrl_r[HPD_CTRL_NIEN];
    end
  end

  // Handshake state machine
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= HPD_IDLE;
    end else if (ha[HPD_HA_SRST]) begin
      state_r <= HPD_IDLE;
    end else begin
      case (state_r)
        HPD_IDLE: begin
          // Start only with a length; without data ready, wait in pause
          if (dc[HPD_DC_START] && len_r != '0) begin
            state_r <= ctrl_r[HPD_CTRL_DMARDY] ? HPD_REQ : HPD_PAUSE;
          end
        end
        HPD_REQ: begin
          // Host answers with acknowledge; abort before it ends at once
          if (dc[HPD_DC_ABORT]) begin
            state_r <= HPD_FINISH;
          end else if (dmack_s) begin
            state_r <= HPD_XFER;
          end
        end
        HPD_XFER: begin
          if (word_done && count_r + 1'b1 == len_r) begin
            state_r <= HPD_FINISH;
          end else if (burst_word_r && !strobe_s && dc[HPD_DC_ABORT]) begin
            state_r <= HPD_FINISH;
          end else if (burst_word_r && !strobe_s && !ctrl_r[HPD_CTRL_DMARDY]) begin
            state_r <= HPD_PAUSE;
          end else if (!dmack_s && !strobe_d_r) begin
            state_r <= HPD_REQ;
          end
        end
        HPD_PAUSE: begin
          // A strobe already under way may still land here; resume only
          // once acknowledge has dropped
          if (word_done && count_r + 1'b1 == len_r) begin
            state_r <= HPD_FINISH;
          end else if (dc[HPD_DC_ABORT]) begin
            state_r <= HPD_FINISH;
          end else if (!dmack_s && ctrl_r[HPD_CTRL_DMARDY]) begin
            state_r <= HPD_REQ;
          end
        end
        HPD_FINISH: begin
          // Wait for the host to drop acknowledge, then release
          if (!dmack_s) begin
            state_r <= HPD_IDLE;
          end
        end
        default: begin
          state_r <= HPD_IDLE;
        end
      endcase
    end
  end

  // Word counter and per-burst word flag
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
      burst_word_r <= 1'b0;
    end else if (state_r == HPD_IDLE && dc[HPD_DC_START]) begin
      count_r <= '0;
      burst_word_r <= 1'b0;
    end else if ((state_r == HPD_XFER || state_r == HPD_PAUSE) && word_done) begin
      count_r <= count_r + 1'b1;
      burst_word_r <= 1'b1;
    end else if (state_r != HPD_XFER) begin
      burst_word_r <= 1'b0;
    end
  end

  // Completion and error flags, cleared by the next start
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else if (state_r == HPD_IDLE && dc[HPD_DC_START]) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (state_r == HPD_FINISH && !dmack_s) begin
        done_r <= 1'b1;
      end
      if (dc[HPD_DC_ABORT] && state_r != HPD_IDLE && state_r != HPD_FINISH) begin
        err_r <= 1'b1;
      end
    end
  end

  // Request pin level and drive enable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dmarq_o <= 1'b0;
      dmarq_oe <= 1'b0;
    end else begin
      dmarq_o <= 1'b0;
      dmarq_oe <= 1'b0;
      if (ha[HPD_HA_SRST]) begin
        dmarq_oe <= 1'b0;
      end else begin
        case (state_r)
          HPD_IDLE: begin
            dmarq_o <= dc[HPD_DC_START] && len_r != '0 && ctrl_r[HPD_CTRL_DMARDY];
            dmarq_oe <= dc[HPD_DC_START] && len_r != '0 && ctrl_r[HPD_CTRL_DMARDY];
          end
          HPD_REQ: begin
            dmarq_o <= ~dc[HPD_DC_ABORT];
            dmarq_oe <= 1'b1;
          end
          HPD_XFER: begin
            dmarq_o <= !((word_done && count_r + 1'b1 == len_r)
                         || (burst_word_r && !strobe_s
                             && (dc[HPD_DC_ABORT] || !ctrl_r[HPD_CTRL_DMARDY])));
            dmarq_oe <= 1'b1;
          end
          HPD_PAUSE: begin
            dmarq_o <= !dmack_s && ctrl_r[HPD_CTRL_DMARDY] && !dc[HPD_DC_ABORT];
            dmarq_oe <= count_r != '0
                        || (!dmack_s && ctrl_r[HPD_CTRL_DMARDY] && !dc[HPD_DC_ABORT]);
          end
          HPD_FINISH: begin
            dmarq_o <= 1'b0;
            dmarq_oe <= dmack_s;
          end
          default: begin
            dmarq_o <= 1'b0;
            dmarq_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: test/host_port_irq_mwdma_tb_top.sv
/* Self-checking bench for the host port: interrupt table, clear rules,
   resets, mode feature and DMA runs. Host pins come from the host model. */
`timescale 1ns/1ps
`default_nettype none
module host_port_irq_mwdma_tb_top;
  import hpd_pkg::*;
  typedef struct packed {logic [31:0] ctrl; logic [31:0] ev; logic exp;} hpd_row_type;
  logic clock, resetn, avs_read, avs_write, avs_waitrequest;
  logic [HPD_AW-1:0] avs_address;
  logic [HPD_DW-1:0] avs_writedata, avs_readdata;
  logic dmack_n, dior_n, diow_n, cs0_n, cs1_n, dmarq_o, dmarq_oe, intrq;
  logic write_dir, host_pause; // Host model controls
  logic [31:0] q; // Last read word
  int num_errors = 0;
  int compares = 0;
  wire logic dmarq_line; // Released line is pulled low
  assign dmarq_line = dmarq_oe ? dmarq_o : 1'b0;
  // Control word, event pulses, expected pending per row
  hpd_row_type rows [16] = '{
    '{32'h000, 32'h001, 1'b1}, '{32'h800, 32'h001, 1'b0},
    '{32'h800, 32'h002, 1'b1}, '{32'h000, 32'h004, 1'b1},
    '{32'h000, 32'h408, 1'b0}, '{32'h000, 32'h008, 1'b1},
    '{32'h220, 32'h010, 1'b1}, '{32'h420, 32'h010, 1'b0},
    '{32'h020, 32'h020, 1'b1}, '{32'h0c0, 32'h040, 1'b1},
    '{32'h040, 32'h040, 1'b0}, '{32'h040, 32'h080, 1'b1},
    '{32'h140, 32'h100, 1'b1}, '{32'h040, 32'h100, 1'b0},
    '{32'h000, 32'h200, 1'b1}, '{32'h018, 32'h200, 1'b0}};
  hpd_top #(.LEN_W(16)) u_dut (.clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dmack_n(dmack_n),
    .dior_n(dior_n), .diow_n(diow_n), .cs0_n(cs0_n), .cs1_n(cs1_n), .dmarq_o(dmarq_o),
    .dmarq_oe(dmarq_oe), .intrq(intrq));
  hpd_host u_host (.clock(clock), .resetn(resetn), .dmarq_line(dmarq_line),
    .write_dir(write_dir), .host_pause(host_pause), .dmack_n(dmack_n), .dior_n(dior_n),
    .diow_n(diow_n), .cs0_n(cs0_n), .cs1_n(cs1_n));
  // Free-running clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Compares one value and counts it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) num_errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  // Reads a register and compares the masked field
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q & m, e);
  endtask
  // Reads until the masked field matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((q & m) !== e && n < 300);
    if (n >= 300) num_errors++;
  endtask
  // Loads length and control, then starts a DMA run
  task automatic start(input logic [31:0] len, input logic [31:0] ctrl);
    bus(1'b1, HPD_OFF_DMALEN, len);
    bus(1'b1, HPD_OFF_CTRL, ctrl);
    bus(1'b1, HPD_OFF_DMACMD, 32'h1);
  endtask
  // Prints counts and the verdict, then ends the run
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, write_dir, host_pause} = '0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      bus(1'b1, HPD_OFF_CTRL, rows[i].ctrl);
      bus(1'b1, HPD_OFF_EVENT, rows[i].ev);
      expect_rd(HPD_OFF_STATUS, 32'h3, {30'h0, rows[i].exp, rows[i].exp});
      bus(1'b1, HPD_OFF_HOSTACC, 32'h1);
      expect_rd(HPD_OFF_STATUS, 32'h1, 32'h0);
    end
    $display("event table done");
    bus(1'b1, HPD_OFF_CTRL, 32'h0);
    bus(1'b1, HPD_OFF_EVENT, 32'h1);
    bus(1'b1, HPD_OFF_CTRL, 32'h8); // Host selects the other unit
    bus(1'b1, HPD_OFF_HOSTACC, 32'h1);
    expect_rd(HPD_OFF_STATUS, 32'h3, 32'h3);
    bus(1'b1, HPD_OFF_CTRL, 32'h2); // Selected but busy
    bus(1'b1, HPD_OFF_HOSTACC, 32'h3);
    expect_rd(HPD_OFF_STATUS, 32'h1, 32'h1);
    bus(1'b1, HPD_OFF_CTRL, 32'h4); // Data request still set
    bus(1'b1, HPD_OFF_HOSTACC, 32'h2);
    expect_rd(HPD_OFF_STATUS, 32'h1, 32'h1);
    bus(1'b1, HPD_OFF_CTRL, 32'h0);
    bus(1'b1, HPD_OFF_HOSTACC, 32'h2);
    expect_rd(HPD_OFF_STATUS, 32'h1, 32'h0);
    $display("clear rules done");
    bus(1'b1, HPD_OFF_CTRL, 32'h1); // Interrupt masked
    bus(1'b1, HPD_OFF_EVENT, 32'h1);
    expect_rd(HPD_OFF_STATUS, 32'h3, 32'h1);
    check(intrq, 32'h0);
    bus(1'b1, HPD_OFF_HOSTACC, 32'h4);
    expect_rd(HPD_OFF_STATUS, 32'h1, 32'h0);
    bus(1'b1, HPD_OFF_FEATURE, 32'h2203);
    bus(1'b1, HPD_OFF_FEATURE, 32'h4402); // Other subcommand leaves mode alone
    expect_rd(HPD_OFF_STATUS, 32'hff00, 32'h2200);
    expect_rd(8'h40, 32'hffffffff, 32'h0);
    bus(1'b1, HPD_OFF_EVENT, 32'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    expect_rd(HPD_OFF_CTRL, 32'h1fff, 32'h1);
    expect_rd(HPD_OFF_STATUS, 32'hff01, 32'h0);
    $display("resets and mode done");
    start(32'd3, 32'h1000);
    poll(HPD_OFF_COUNT, 32'hffff, 32'h1);
    host_pause <= 1'b1; // Host withholds strobes
    repeat (30) @(posedge clock);
    check(dmarq_o, 32'h1);
    host_pause <= 1'b0;
    poll(HPD_OFF_STATUS, 32'h1c, 32'h0);
    expect_rd(HPD_OFF_COUNT, 32'hffff, 32'h3);
    check(dmarq_oe, 32'h0);
    expect_rd(HPD_OFF_STATUS, 32'h60, 32'h20);
    $display("host pause run done");
    write_dir <= 1'b1;
    start(32'd6, 32'h0); // Data not ready yet
    repeat (20) @(posedge clock);
    check(dmarq_oe, 32'h0);
    bus(1'b1, HPD_OFF_CTRL, 32'h1000);
    poll(HPD_OFF_COUNT, 32'hffff, 32'h1);
    bus(1'b1, HPD_OFF_CTRL, 32'h0); // Device runs out of data
    repeat (40) @(posedge clock);
    check(dmarq_o, 32'h0);
    bus(1'b1, HPD_OFF_CTRL, 32'h1000);
    poll(HPD_OFF_STATUS, 32'h1c, 32'h0);
    expect_rd(HPD_OFF_COUNT, 32'hffff, 32'h6);
    $display("device pause run done");
    start(32'd5, 32'h1000);
    poll(HPD_OFF_COUNT, 32'hffff, 32'h1);
    bus(1'b1, HPD_OFF_DMACMD, 32'h2); // Abort in mid-run
    poll(HPD_OFF_STATUS, 32'h1c, 32'h0);
    expect_rd(HPD_OFF_STATUS, 32'h40, 32'h40);
    check(dmarq_o, 32'h0);
    $display("abort run done");
    give_verdict();
  end
endmodule
`default_nettype wire

// file: test/hpd_host.sv
/* Host adapter model for the DMA handshake.
   Assumes the request line is already resolved, pulled low when released. */
`timescale 1ns/1ps
`default_nettype none
module hpd_host (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Resolved request line
  input wire logic dmarq_line,
  // Bench controls: strobe direction and host pause
  input wire logic write_dir,
  input wire logic host_pause,
  // Host pins, active low
  output logic dmack_n,
  output logic dior_n,
  output logic diow_n,
  output logic cs0_n,
  output logic cs1_n
);
  // Idle host holds one chip select low, with no strobes; on a
  // request: selects off, acknowledge, one strobe per word
  always begin
    @(posedge clock);
    if (!resetn) begin
      dmack_n <= 1'b1;
      dior_n <= 1'b1;
      diow_n <= 1'b1;
      cs0_n <= 1'b0;
      cs1_n <= 1'b1;
    end else if (dmarq_line && !host_pause) begin
      cs0_n <= 1'b1;
      cs1_n <= 1'b1;
      @(posedge clock);
      dmack_n <= 1'b0;
      repeat (2) @(posedge clock);
      // At least one word per acknowledge; each later strobe starts at
      // the edge where the request was seen high
      do begin
        dior_n <= write_dir;
        diow_n <= !write_dir;
        repeat (3) @(posedge clock);
        dior_n <= 1'b1;
        diow_n <= 1'b1;
        repeat (8) @(posedge clock);
      end while (dmarq_line && !host_pause);
      dmack_n <= 1'b1;
      repeat (2) @(posedge clock);
      cs0_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: test/hpd_sva.sv
/* Checker for the host port: bus answer timing, request line drive
   and causes of interrupt line changes. Sees only top-level ports. */
`timescale 1ns/1ps
`default_nettype none
module hpd_chk #(
  parameter int LEN_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register bus
  input wire logic [hpd_pkg::HPD_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [hpd_pkg::HPD_DW-1:0] avs_writedata,
  input wire logic [hpd_pkg::HPD_DW-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Host pins
  input wire logic dmack_n,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  // Device pins
  input wire logic dmarq_o,
  input wire logic dmarq_oe,
  input wire logic intrq
);
  import hpd_pkg::*;
  logic dmarq_prev_r; // Request level one edge ago
  logic strobe_idle_r; // Both strobes high one edge ago
  logic word_seen_r; // A strobe ended under acknowledge in this burst
  // Notes whether a word moved since the request last rose
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dmarq_prev_r <= 1'b0;
      strobe_idle_r <= 1'b1;
      word_seen_r <= 1'b0;
    end else begin
      dmarq_prev_r <= dmarq_o;
      strobe_idle_r <= dior_n & diow_n;
      if (dmarq_o && !dmarq_prev_r) begin
        word_seen_r <= 1'b0;
      end else if (!dmack_n && dior_n && diow_n && !strobe_idle_r) begin
        word_seen_r <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  chk_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_drive_req: assert property (dmarq_o |-> dmarq_oe)
    else $error("request asserted while line released");
  chk_oe_start: assert property ($rose(dmarq_oe) |-> dmarq_o)
    else $error("line driven without a request");
  chk_resume_ack: assert property ($rose(dmarq_o) |-> $past(dmack_n, 3))
    else $error("request raised while acknowledge still low");
  chk_irq_set_cause: assert property ($rose(intrq) |-> $past(avs_write && !avs_waitrequest, 2))
    else $error("interrupt rose without a register write");
  chk_irq_clear_cause: assert property ($fell(intrq) |-> $past(avs_write && !avs_waitrequest, 2))
    else $error("interrupt fell without a register write");
  chk_hold_ack: assert property ((dmarq_oe && !dmack_n) [*3] |=> dmarq_oe)
    else $error("line released while acknowledged");
  chk_word_first: assert property ($fell(dmarq_o) |-> word_seen_r)
    else $error("request dropped before any word moved");
  // Main scenarios reached
  cov_req_rise: cover property ($rose(dmarq_o));
  cov_irq_rise: cover property ($rose(intrq));
  cov_dev_pause: cover property ($fell(dmarq_o) && !dmack_n);
endmodule
bind hpd_top hpd_chk #(.LEN_W(LEN_W)) u_chk (
  .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .dmack_n(dmack_n), .dior_n(dior_n),
  .diow_n(diow_n), .cs0_n(cs0_n), .cs1_n(cs1_n), .dmarq_o(dmarq_o),
  .dmarq_oe(dmarq_oe), .intrq(intrq)
);
`default_nettype wire
